// ### src/fcp_host.sv
`timescale 1ns/1ps
module fcp_host #(
    parameter int SCK_HALF = 10,
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    fcp_if.host              link,
    input  wire logic        cmd_valid_in,
    output logic             cmd_ready_out,
    input  wire logic [7:0]  cmd_op_in,
    input  wire logic [23:0] cmd_addr_in,
    input  wire logic [15:0] cmd_len_in,
    input  wire logic        mode3_in,
    input  wire logic        par_in,
    output logic             rd_valid_out,
    output logic [7:0]       rd_data_out,
    input  wire logic        rd_ready_in
);
    import fcp_pkg::*;

    initial begin
        if (SCK_HALF < 6) $error("fcp_host SCK_HALF too short for input sampling");
    end

    typedef enum logic [2:0] {
        FCP_H_RST   = 3'b000,
        FCP_H_REC   = 3'b001,
        FCP_H_IDLE  = 3'b010,
        FCP_H_SETUP = 3'b011,
        FCP_H_LOW   = 3'b100,
        FCP_H_HIGH  = 3'b101,
        FCP_H_END   = 3'b110,
        FCP_H_GAP   = 3'b111
    } fcp_hst_t;

    fcp_hst_t    st_q;
    logic [15:0] tm_q;
    logic [2:0]  bit_q;
    logic [3:0]  bi_q;
    logic [3:0]  hdr_q;
    logic [15:0] rem_q;
    logic [7:0]  op_q;
    logic [23:0] addr_q;
    logic        m3_q;
    logic        par_q;
    logic        data_q;
    logic [7:0]  rx_q;
    logic        push_q;
    logic        fifo_ready;
    logic [7:0]  tx_byte;
    logic [8:0]  sy1_q;
    logic [8:0]  sy2_q;
    logic [8:0]  sy3_q;
    logic [8:0]  syf_q;

    // Pin inputs: three stages, a change counts once stages two and three agree
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sy1_q <= '0;
            sy2_q <= '0;
            sy3_q <= '0;
            syf_q <= '0;
        end else begin
            sy1_q <= {link.so_line, link.parallel_byte_bus};
            sy2_q <= sy1_q;
            sy3_q <= sy2_q;
            syf_q <= (sy2_q & sy3_q) | (syf_q & (sy2_q ^ sy3_q));
        end
    end

    always_comb begin
        unique case (bi_q)
            4'h0:    tx_byte = op_q;
            4'h1:    tx_byte = addr_q[23:16];
            4'h2:    tx_byte = addr_q[15:8];
            4'h3:    tx_byte = addr_q[7:0];
            default: tx_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_q                <= FCP_H_RST;
            tm_q                <= '0;
            bit_q               <= '0;
            bi_q                <= '0;
            hdr_q               <= '0;
            rem_q               <= '0;
            op_q                <= '0;
            addr_q              <= '0;
            m3_q                <= 1'b0;
            par_q               <= 1'b0;
            data_q              <= 1'b0;
            rx_q                <= '0;
            push_q              <= 1'b0;
            cmd_ready_out       <= 1'b0;
            link.cs_n           <= 1'b1;
            link.sck            <= 1'b0;
            link.si             <= 1'b0;
            link.pbus_host      <= '0;
            link.pbus_host_oe_n <= 1'b1;
            link.interface_select <= 1'b1;
            link.reset_n        <= 1'b0;
        end else begin
            push_q <= 1'b0;
            tm_q   <= tm_q + 16'h0001;
            unique case (st_q)
                FCP_H_RST: begin
                    if (tm_q == 16'(RST_CYC - 1)) begin
                        st_q         <= FCP_H_REC;
                        tm_q         <= '0;
                        link.reset_n <= 1'b1;
                    end
                end
                FCP_H_REC: begin
                    if (tm_q == 16'(REC_CYC - 1)) begin
                        st_q          <= FCP_H_IDLE;
                        cmd_ready_out <= 1'b1;
                    end
                end
                FCP_H_IDLE: begin
                    if (cmd_valid_in) begin
                        cmd_ready_out <= 1'b0;
                        op_q          <= cmd_op_in;
                        addr_q        <= cmd_addr_in;
                        rem_q         <= cmd_len_in;
                        hdr_q         <= (fcp_hdr_len(cmd_op_in) == HDR_NONE) ? HDR_STATUS : fcp_hdr_len(cmd_op_in);
                        m3_q          <= mode3_in;
                        par_q         <= par_in;
                        link.interface_select <= !par_in;
                        link.sck      <= mode3_in;
                        bi_q          <= '0;
                        bit_q         <= '0;
                        data_q        <= 1'b0;
                        tm_q          <= '0;
                        st_q          <= FCP_H_SETUP;
                    end
                end
                FCP_H_SETUP: begin
                    link.cs_n <= 1'b0;
                    if (tm_q == 16'(CS_CYC - 1)) begin
                        st_q <= FCP_H_LOW;
                        tm_q <= '0;
                    end
                end
                FCP_H_LOW: begin
                    link.sck <= 1'b0;
                    // A push still in flight is not yet seen in fifo_ready: wait one cycle for it
                    if (data_q && bit_q == 3'h0 && tm_q == 16'h0000 && (push_q || !fifo_ready)) begin
                        tm_q <= '0;
                    end else begin
                        link.si             <= tx_byte[~bit_q];
                        link.pbus_host      <= tx_byte;
                        link.pbus_host_oe_n <= data_q || !par_q;
                        if (tm_q == 16'(SCK_HALF - 1)) begin
                            st_q     <= FCP_H_HIGH;
                            tm_q     <= '0;
                            link.sck <= 1'b1;
                            rx_q     <= par_q ? syf_q[7:0] : {rx_q[6:0], syf_q[8]};
                        end
                    end
                end
                FCP_H_HIGH: begin
                    if (tm_q == 16'(SCK_HALF - 1)) begin
                        tm_q  <= '0;
                        st_q  <= FCP_H_LOW;
                        bit_q <= par_q ? 3'h0 : bit_q + 3'h1;
                        if (par_q || bit_q == 3'h7) begin
                            if (data_q) begin
                                push_q <= 1'b1;
                                rem_q  <= rem_q - 16'h0001;
                                if (rem_q == 16'h0001) begin
                                    st_q <= FCP_H_END;
                                end
                            end else begin
                                bi_q <= bi_q + 4'h1;
                                if (bi_q == hdr_q) begin
                                    data_q <= 1'b1;
                                    if (rem_q == 16'h0000) begin
                                        st_q <= FCP_H_END;
                                    end
                                end
                            end
                        end
                    end
                end
                FCP_H_END: begin
                    link.sck            <= m3_q;
                    link.pbus_host_oe_n <= 1'b1;
                    if (tm_q == 16'(SCK_HALF - 1)) begin
                        link.cs_n <= 1'b1;
                        tm_q      <= '0;
                        st_q      <= FCP_H_GAP;
                    end
                end
                FCP_H_GAP: begin
                    if (tm_q == 16'(CS_CYC - 1)) begin
                        st_q          <= FCP_H_IDLE;
                        cmd_ready_out <= 1'b1;
                    end
                end
            endcase
        end
    end

    fcp_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (clk_in),
        .rst_in        (rst_in),
        .in_valid_in   (push_q),
        .in_ready_out  (fifo_ready),
        .in_data_in    (rx_q),
        .out_valid_out (rd_valid_out),
        .out_ready_in  (rd_ready_in),
        .out_data_out  (rd_data_out)
    );
endmodule

// ### include/fcp_pkg.sv
// Summary of operation
// - Accept frame start with clock idle low/high
// - Capture serial bits or bytes on rising clock
// - Clock idle low/high frames both work
// - Chip select high before reset release
// - Opcode 68H streams whole array continuously
// - Opcode 69H burst read, delayed data
// - Opcode E8H continuous array read, both buses
// - Opcode D2H reads one main page
// - Opcodes D4H/D6H read buffer one/two
// - Opcode D7H streams status, no address
// - Host programs pages directly or via buffer
// - Rewrite each sector page per 10,000 operations
// - Host keeps refresh page pointer for rewrites
// - Sector from page address bits 12..3
package fcp_pkg;
    localparam logic [7:0] OP_CONT_LEGACY = 8'h68;
    localparam logic [7:0] OP_BURST       = 8'h69;
    localparam logic [7:0] OP_CONT_SPI    = 8'hE8;
    localparam logic [7:0] OP_PAGE_RD     = 8'hD2;
    localparam logic [7:0] OP_BUF1_RD     = 8'hD4;
    localparam logic [7:0] OP_BUF2_RD     = 8'hD6;
    localparam logic [7:0] OP_STATUS      = 8'hD7;

    localparam logic [3:0] HDR_NONE   = 4'hF;
    localparam logic [3:0] HDR_ARRAY  = 4'h7;
    localparam logic [3:0] HDR_BURST  = 4'h8;
    localparam logic [3:0] HDR_BUF    = 4'h4;
    localparam logic [3:0] HDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_LAST  = 4'h3;

    localparam logic [1:0] REG_MAIN = 2'h0;
    localparam logic [1:0] REG_BUF1 = 2'h1;
    localparam logic [1:0] REG_BUF2 = 2'h2;

    localparam int PAGE_LSB    = 11;
    localparam int PA_TOP      = 12;
    localparam int PA_SEC_LSB  = 8;
    localparam int PA_ZERO_LSB = 3;

    localparam int CLK_NS    = 10;
    localparam int T_RST_NS  = 10000;
    localparam int T_REC_NS  = 1000;
    localparam int T_CS_NS   = 250;
    localparam int RST_CYC   = (T_RST_NS + CLK_NS - 1) / CLK_NS;
    localparam int REC_CYC   = (T_REC_NS + CLK_NS - 1) / CLK_NS;
    localparam int CS_CYC    = (T_CS_NS + CLK_NS - 1) / CLK_NS;

    typedef logic [7:0] fcp_byte_t;

    // Bytes between opcode and first data byte
    function automatic logic [3:0] fcp_hdr_len(input logic [7:0] op);
        unique case (op)
            OP_CONT_LEGACY, OP_CONT_SPI, OP_PAGE_RD: fcp_hdr_len = HDR_ARRAY;
            OP_BURST:                                fcp_hdr_len = HDR_BURST;
            OP_BUF1_RD, OP_BUF2_RD:                  fcp_hdr_len = HDR_BUF;
            OP_STATUS:                               fcp_hdr_len = HDR_STATUS;
            default:                                 fcp_hdr_len = HDR_NONE;
        endcase
    endfunction

    function automatic logic [1:0] fcp_region(input logic [7:0] op);
        fcp_region = (op == OP_BUF1_RD) ? REG_BUF1 : (op == OP_BUF2_RD) ? REG_BUF2 : REG_MAIN;
    endfunction

    function automatic logic [5:0] fcp_sector(input logic [PA_TOP:0] pa);
        if (pa[PA_TOP:PA_ZERO_LSB] == '0) begin
            fcp_sector = 6'h00;
        end else begin
            fcp_sector = 6'({1'b0, pa[PA_TOP:PA_SEC_LSB]}) + 6'h01;
        end
    endfunction
endpackage

// ### include/fcp_if.sv
`timescale 1ns/1ps
interface fcp_if;
    logic       cs_n;
    logic       sck;
    logic       si;
    logic       so;
    logic       so_oe_n;
    logic [7:0] pbus_dev;
    logic       pbus_dev_oe_n;
    logic [7:0] pbus_host;
    logic       pbus_host_oe_n;
    logic       interface_select;
    logic       reset_n;
    logic       so_line;
    logic [7:0] parallel_byte_bus;

    // Wire levels; undriven lines rest high
    assign so_line = so_oe_n ? 1'b1 : so;
    assign parallel_byte_bus = !pbus_dev_oe_n ? pbus_dev : !pbus_host_oe_n ? pbus_host : 8'hFF;

    modport dev (input cs_n, sck, si, interface_select, reset_n, parallel_byte_bus,
                 output so, so_oe_n, pbus_dev, pbus_dev_oe_n);
    modport host (input so_line, parallel_byte_bus,
                  output cs_n, sck, si, pbus_host, pbus_host_oe_n, interface_select, reset_n);
endinterface

// ### src/fcp_fifo.sv
`timescale 1ns/1ps
module fcp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    localparam int PW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << PW) != DEPTH) $error("fcp_fifo DEPTH must be a power of two");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wp_q;
    logic [PW-1:0]    rp_q;
    logic [PW:0]      cnt_q;
    logic [PW:0]      cnt_d;
    logic             push;
    logic             pop;

    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    assign out_data_out = mem_q[rp_q];

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_q[wp_q] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wp_q          <= '0;
            rp_q          <= '0;
            cnt_q         <= '0;
            in_ready_out  <= 1'b0;
            out_valid_out <= 1'b0;
        end else begin
            wp_q          <= wp_q + PW'(push);
            rp_q          <= rp_q + PW'(pop);
            cnt_q         <= cnt_d;
            in_ready_out  <= cnt_d != (PW+1)'(DEPTH);
            out_valid_out <= cnt_d != '0;
        end
    end
endmodule

// ### src/fcp_dev.sv
`timescale 1ns/1ps
module fcp_dev #(
    parameter int AW = 8
) (
    input  wire logic            clk_in,
    input  wire logic            rst_in,
    fcp_if.dev                   link,
    input  wire logic            load_we_in,
    input  wire logic [1:0]      load_region_in,
    input  wire logic [AW-1:0]   load_addr_in,
    input  wire logic [7:0]      load_data_in,
    input  wire logic [7:0]      status_in,
    output logic                 cmd_valid_out,
    output logic [7:0]           cmd_op_out,
    output logic [23:0]          cmd_addr_out,
    output logic [5:0]           cmd_sector_out
);
    import fcp_pkg::*;

    initial begin
        if (AW < 1 || AW > PAGE_LSB) $error("fcp_dev AW out of range");
    end

    typedef enum logic [1:0] {
        FCP_L_OP   = 2'b00,
        FCP_L_HDR  = 2'b01,
        FCP_L_DATA = 2'b10,
        FCP_L_IGN  = 2'b11
    } fcp_lst_t;

    // Byte storage: main array and two buffers, filled from the system side
    logic [7:0] mem_q [4 << AW];

    always_ff @(posedge clk_in) begin
        if (load_we_in) begin
            mem_q[{load_region_in, load_addr_in}] <= load_data_in;
        end
    end

    // Link side: frame state cleared whenever chip select is high
    logic      link_rst;
    fcp_lst_t  st_q;
    logic [2:0] bit_q;
    logic [6:0] sh_q;
    logic [3:0] cnt_q;
    logic [3:0] hdr_q;
    logic [7:0] op_q;
    logic [23:0] addr_q;
    logic [7:0] cur_q;
    logic       ev_tog_q;
    logic [7:0] ev_op_q;
    logic [23:0] ev_addr_q;
    logic [7:0] st_s1_q;
    logic [7:0] st_s2_q;
    logic [7:0] st_s3_q;
    logic [7:0] stat_q;
    logic       par;
    logic       byte_end;
    logic [7:0] rx_byte;
    logic [3:0] hdr_new;
    logic [23:0] addr_next;
    logic [23:0] addr_full;

    assign link_rst  = link.cs_n || !link.reset_n;
    assign par       = !link.interface_select;
    assign byte_end  = par || (bit_q == 3'h7);
    assign rx_byte   = par ? link.parallel_byte_bus : {sh_q, link.si};
    assign hdr_new   = fcp_hdr_len(rx_byte);
    assign addr_full = {addr_q[15:0], rx_byte};

    // Page and buffer reads wrap in the page; array reads run through all of it
    always_comb begin
        if (op_q == OP_PAGE_RD || op_q == OP_BUF1_RD || op_q == OP_BUF2_RD) begin
            addr_next = {addr_q[23:PAGE_LSB], addr_q[PAGE_LSB-1:0] + PAGE_LSB'(1)};
        end else begin
            addr_next = addr_q + 24'h000001;
        end
    end

    // Status sampled into the link domain; only agreed values pass
    always_ff @(posedge link.sck or posedge rst_in) begin
        if (rst_in) begin
            st_s1_q <= '0;
            st_s2_q <= '0;
            st_s3_q <= '0;
            stat_q  <= '0;
        end else begin
            st_s1_q <= status_in;
            st_s2_q <= st_s1_q;
            st_s3_q <= st_s2_q;
            if (st_s2_q == st_s3_q) begin
                stat_q <= st_s3_q;
            end
        end
    end

    // Inputs taken on the rising clock edge, either idle level
    always_ff @(posedge link.sck or posedge link_rst) begin
        if (link_rst) begin
            bit_q <= '0;
            sh_q  <= '0;
        end else begin
            bit_q <= par ? 3'h0 : bit_q + 3'h1;
            sh_q  <= rx_byte[6:0];
        end
    end

    always_ff @(posedge link.sck or posedge link_rst) begin
        if (link_rst) begin
            st_q   <= FCP_L_OP;
            cnt_q  <= '0;
            hdr_q  <= '0;
            op_q   <= '0;
            addr_q <= '0;
            cur_q  <= '0;
        end else if (byte_end) begin
            unique case (st_q)
                FCP_L_OP: begin
                    op_q  <= rx_byte;
                    hdr_q <= hdr_new;
                    cnt_q <= 4'h1;
                    if (hdr_new == HDR_NONE) begin
                        st_q <= FCP_L_IGN;
                    end else if (hdr_new == HDR_STATUS) begin
                        st_q  <= FCP_L_DATA;
                        cur_q <= stat_q;
                    end else begin
                        st_q <= FCP_L_HDR;
                    end
                end
                FCP_L_HDR: begin
                    if (cnt_q <= ADDR_LAST) begin
                        addr_q <= addr_full;
                    end
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == hdr_q) begin
                        st_q  <= FCP_L_DATA;
                        cur_q <= mem_q[{fcp_region(op_q), addr_q[AW-1:0]}];
                    end
                end
                FCP_L_DATA: begin
                    if (op_q == OP_STATUS) begin
                        cur_q <= stat_q;
                    end else begin
                        addr_q <= addr_next;
                        cur_q  <= mem_q[{fcp_region(op_q), addr_next[AW-1:0]}];
                    end
                end
                FCP_L_IGN: begin
                    st_q <= FCP_L_IGN;
                end
            endcase
        end
    end

    // Command word handed to the system side with a toggle
    always_ff @(posedge link.sck or posedge rst_in) begin
        if (rst_in) begin
            ev_tog_q  <= 1'b0;
            ev_op_q   <= '0;
            ev_addr_q <= '0;
        end else if (!link_rst && byte_end && ((st_q == FCP_L_HDR && cnt_q == hdr_q)
                     || (st_q == FCP_L_OP && hdr_new == HDR_STATUS))) begin
            ev_tog_q  <= !ev_tog_q;
            ev_op_q   <= (st_q == FCP_L_OP) ? rx_byte : op_q;
            ev_addr_q <= (st_q == FCP_L_OP) ? 24'h000000 : addr_q;
        end
    end

    // Outputs change on the falling edge and float as soon as chip select rises
    always_ff @(negedge link.sck or posedge link_rst) begin
        if (link_rst) begin
            link.so            <= 1'b0;
            link.so_oe_n       <= 1'b1;
            link.pbus_dev      <= '0;
            link.pbus_dev_oe_n <= 1'b1;
        end else begin
            link.so            <= cur_q[~bit_q];
            link.so_oe_n       <= !(st_q == FCP_L_DATA && !par);
            link.pbus_dev      <= cur_q;
            link.pbus_dev_oe_n <= !(st_q == FCP_L_DATA && par);
        end
    end

    // System side: toggle sync and command report
    logic tg_s1_q;
    logic tg_s2_q;
    logic tg_s3_q;
    logic tg_f_q;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            tg_s1_q <= 1'b0;
            tg_s2_q <= 1'b0;
            tg_s3_q <= 1'b0;
            tg_f_q  <= 1'b0;
        end else begin
            tg_s1_q <= ev_tog_q;
            tg_s2_q <= tg_s1_q;
            tg_s3_q <= tg_s2_q;
            if (tg_s2_q == tg_s3_q) begin
                tg_f_q <= tg_s3_q;
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cmd_valid_out  <= 1'b0;
            cmd_op_out     <= '0;
            cmd_addr_out   <= '0;
            cmd_sector_out <= '0;
        end else begin
            cmd_valid_out <= (tg_s2_q == tg_s3_q) && (tg_s3_q != tg_f_q);
            if ((tg_s2_q == tg_s3_q) && (tg_s3_q != tg_f_q)) begin
                cmd_op_out     <= ev_op_q;
                cmd_addr_out   <= ev_addr_q;
                cmd_sector_out <= fcp_sector(ev_addr_q[PAGE_LSB+PA_TOP:PAGE_LSB]);
            end
        end
    end
endmodule

// ### test/fcp_props.sv
`timescale 1ns/1ps
module fcp_props (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic so,
    input wire logic so_oe_n,
    input wire logic pbus_dev_oe_n,
    input wire logic pbus_host_oe_n,
    input wire logic reset_n
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);

    a_cs_at_release: assert property ($rose(reset_n) |-> cs_n)
        else $error("chip select low at reset release");
    a_idle_float: assert property (cs_n && $past(cs_n, 4) |-> so_oe_n && pbus_dev_oe_n)
        else $error("device drives outside a frame");
    a_no_bus_fight: assert property (!(!pbus_dev_oe_n && !pbus_host_oe_n))
        else $error("both ends drive the byte bus");
    a_cs_fall_quiet: assert property ($fell(cs_n) |-> $stable(sck)[*8])
        else $error("clock moved right after frame start");
    a_first_edge: assert property ($fell(cs_n) |-> ##[1:60] $changed(sck))
        else $error("no clock edge soon after frame start");
    a_si_holds_high: assert property (!cs_n && sck && $past(sck) |-> $stable(si))
        else $error("serial input changed while clock high");
    a_so_moves_low: assert property (!so_oe_n && $past(!so_oe_n) && $changed(so) |-> !sck)
        else $error("serial output changed while clock high");
    a_cs_high_gap: assert property ($rose(cs_n) |-> cs_n[*8])
        else $error("chip select high time too short");
endmodule

// ### test/tb_flash_command_port.sv
`timescale 1ns/1ps
module tb_flash_command_port;
    import fcp_pkg::*;
    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        cv = 1'b0, cr, m3 = 1'b0, ps = 1'b0, rv, rr = 1'b1, we = 1'b0, dv;
    logic [7:0]  op = 8'h00, rd, ld = 8'h00, st = 8'h00, la = 8'h00, d_op;
    logic [1:0]  lr = 2'h0;
    logic [23:0] ad = 24'h0, d_addr;
    logic [15:0] len = 16'h0;
    logic [5:0]  d_sec;
    logic [7:0]  got [$];
    int          n_fail = 0, total_checks = 0, np = 0;

    fcp_if link ();
    fcp_host u_fcp_host (.clk_in(clk_in), .rst_in(rst_in), .link(link.host), .cmd_valid_in(cv), .cmd_ready_out(cr),
        .cmd_op_in(op), .cmd_addr_in(ad), .cmd_len_in(len), .mode3_in(m3), .par_in(ps), .rd_valid_out(rv),
        .rd_data_out(rd), .rd_ready_in(rr));
    fcp_dev u_fcp_dev (.clk_in(clk_in), .rst_in(rst_in), .link(link.dev), .load_we_in(we), .load_region_in(lr),
        .load_addr_in(la), .load_data_in(ld), .status_in(st), .cmd_valid_out(dv), .cmd_op_out(d_op),
        .cmd_addr_out(d_addr), .cmd_sector_out(d_sec));
    fcp_props u_fcp_props (.clk_in(clk_in), .rst_in(rst_in), .cs_n(link.cs_n), .sck(link.sck), .si(link.si),
        .so(link.so), .so_oe_n(link.so_oe_n), .pbus_dev_oe_n(link.pbus_dev_oe_n),
        .pbus_host_oe_n(link.pbus_host_oe_n), .reset_n(link.reset_n));

    initial forever #5 clk_in = ~clk_in;
    always @(posedge clk_in) if (dv === 1'b1) np <= np + 1;

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One frame; stall holds the read side off for that many cycles
    task automatic run(input logic [7:0] o, input logic [23:0] a, input int n, input logic m, input logic p,
                       input int stall, input int npulse = 1);
        int k;
        int n0;
        got.delete();
        @(negedge clk_in);
        op = o;
        ad = a;
        len = 16'(n);
        m3 = m;
        ps = p;
        rr = (stall == 0);
        cv = 1'b1;
        k = 0;
        do begin
            @(posedge clk_in);
            k++;
        end while (cr !== 1'b1 && k < 5000);
        if (cr !== 1'b1) begin
            n_fail++;
            finish_test();
        end
        n0 = np;
        @(negedge clk_in);
        cv = 1'b0;
        for (k = 0; k < 40000 && got.size() < n; k++) begin
            @(posedge clk_in);
            if (rv === 1'b1 && rr === 1'b1) got.push_back(rd);
            if (k == stall && rr !== 1'b1) begin
                @(negedge clk_in);
                rr = 1'b1;
            end
        end
        if (got.size() < n) begin
            n_fail++;
            finish_test();
        end
        check("cmd pulse", 24'(np - n0), 24'(npulse));
    endtask

    // Unknown opcode: no command report, output stays released
    task automatic t_unknown();
        run(8'h3C, 24'h0, 2, 1'b0, 1'b0, 0, 0);
        foreach (got[k]) check("ignored", 24'(got[k]), 24'hFF);
    endtask

    task automatic t_status();
        st = 8'hA5;
        run(OP_STATUS, 24'h0, 3, 1'b0, 1'b0, 0);
        foreach (got[k]) check("status", 24'(got[k]), 24'hA5);
        check("status addr", d_addr, 24'h0);
    endtask

    task automatic t_buf();
        for (int r = 1; r <= 2; r++) begin
            run(r == 1 ? OP_BUF1_RD : OP_BUF2_RD, 24'h4, 3, 1'b1, 1'b1, 0);
            foreach (got[k]) check("buffer", 24'(got[k]), 24'({2'(r), 6'(4 + k)}));
        end
    endtask

    task automatic t_page();
        logic [23:0] a [4] = '{24'h100005, 24'h000803, 24'hFFF802, 24'h004001};
        logic [5:0]  s [4] = '{6'h03, 6'h00, 6'h20, 6'h01};
        for (int i = 0; i < 4; i++) begin
            run(OP_PAGE_RD, a[i], 1, 1'b1, 1'b0, 0);
            check("page data", 24'(got[0]), 24'(a[i][5:0]));
            check("sector", 24'(d_sec), 24'(s[i]));
            check("page addr", d_addr, a[i]);
        end
    endtask

    task automatic t_cont();
        logic [7:0] o [3] = '{OP_CONT_LEGACY, OP_BURST, OP_CONT_SPI};
        for (int i = 0; i < 3; i++) begin
            run(o[i], 24'h8, 2, i[0], i > 0, 0);
            foreach (got[k]) check("array", 24'(got[k]), 24'(8 + k));
            check("array op", 24'(d_op), 24'(o[i]));
        end
        run(OP_CONT_SPI, 24'h10, 12, 1'b1, 1'b1, 3000);
        foreach (got[k]) check("stalled", 24'(got[k]), 24'(16 + k));
    endtask

    initial begin
        repeat (5) @(negedge clk_in);
        rst_in = 1'b0;
        we = 1'b1;
        for (int r = 0; r < 3; r++) begin
            for (int i = 0; i < 32; i++) begin
                lr = 2'(r);
                la = 8'(i);
                ld = {2'(r), 6'(i)};
                @(negedge clk_in);
            end
        end
        we = 1'b0;
        t_status();
        t_unknown();
        t_buf();
        t_page();
        t_cont();
        finish_test();
    end
endmodule
